/* hdl/tpo_pkg.sv */
// Purpose: Shared constants, types and helpers of the timed pattern output block.
// Assumes: Registers are word slots on APB; a slot index times four is the byte address.
// Notes:   Every offset, field position, reset value and encoding is named here once.
package tpo_pkg;

	// Group geometry: four groups of four pins.
	localparam int unsigned NUM_GROUPS = 4;
	localparam int unsigned GROUP_W    = 4;
	localparam int unsigned NUM_PINS   = 16;
	localparam int unsigned NUM_CMP    = 4;
	localparam int unsigned SEL_W      = 2;

	// Register slot indices; byte address is four times the index.
	localparam logic [29:0] IDX_PORT_DATA  = 30'h05FFFFC2;
	localparam logic [29:0] IDX_PINFN_HIGH = 30'h05FFFFCC;
	localparam logic [29:0] IDX_PINFN_LOW  = 30'h05FFFFCE;
	localparam logic [29:0] IDX_MODE       = 30'h05FFFFF0;
	localparam logic [29:0] IDX_TRIG_SEL   = 30'h05FFFFF1;
	localparam logic [29:0] IDX_EN_HIGH    = 30'h05FFFFF2;
	localparam logic [29:0] IDX_EN_LOW     = 30'h05FFFFF3;
	localparam logic [29:0] IDX_NEXT_HIGH  = 30'h05FFFFF4;
	localparam logic [29:0] IDX_NEXT_LOW   = 30'h05FFFFF5;
	localparam logic [29:0] IDX_NEXT_HIGH2 = 30'h05FFFFF6;
	localparam logic [29:0] IDX_NEXT_LOW2  = 30'h05FFFFF7;
	localparam logic [29:0] IDX_GAP        = 30'h05FFFFF8;

	// Reset values.
	localparam logic [15:0] RST_PORT_DATA = 16'h0000;
	localparam logic [15:0] RST_PINFN     = 16'h0000;
	localparam logic [7:0]  RST_MODE      = 8'hF0;
	localparam logic [7:0]  RST_TRIG_SEL  = 8'hFF;
	localparam logic [7:0]  RST_ENABLE    = 8'h00;
	localparam logic [7:0]  RST_NEXT      = 8'h00;
	localparam logic [7:0]  RST_GAP       = 8'h01;

	// Field layout and encodings.
	localparam logic [3:0]  MODE_RSVD_ONES = 4'hF;
	localparam logic [3:0]  NIB_RSVD_ONES  = 4'hF;
	localparam logic [7:0]  BYTE_RSVD_ONES = 8'hFF;
	localparam logic [1:0]  PINFN_PATTERN  = 2'b11;
	localparam int unsigned MODE_NOV_LSB   = 0;

	// Non-overlap sequencer state of one group.
	typedef enum logic [0:0]
	{
		TPO_IDLE = 1'b0,
		TPO_GAP  = 1'b1
	} tpo_gstate_t;

	// Decode key: only index bits 27..24 and 8..0 take part.
	function automatic logic [12:0] tpo_key(input logic [29:0] idx);
	begin
		return {idx[27:24], idx[8:0]};
	end
	endfunction : tpo_key

endpackage : tpo_pkg

/* hdl/tpo_grp_if.sv */
// Purpose: Carries one pattern group's controls and its port data update.
// Assumes: One instance per group, all on pclk.
// Notes:   The register file drives the ctl side, the group sequencer the grp side.
`timescale 1ns/10ps
interface tpo_grp_if;
	logic [1:0] sel;      // Compare channel that triggers this group.
	logic [3:0] ner;      // Per-pin pattern enable.
	logic [3:0] ndr;      // Next pattern nibble.
	logic       nov;      // Non-overlap mode.
	logic [3:0] port;     // Current port data nibble.
	logic [3:0] upd_en;   // Bits to update this cycle.
	logic [3:0] upd_val;  // Values for the updated bits.

	modport ctl (output sel, output ner, output ndr, output nov, output port,
		input upd_en, input upd_val);
	modport grp (input sel, input ner, input ndr, input nov, input port,
		output upd_en, output upd_val);
endinterface : tpo_grp_if

/* hdl/tpo_ndr_map.sv */
// Purpose: Maps one next-pattern byte onto its main and alternate register slots.
// Assumes: Write strobes arrive already qualified by the bus access and byte lane.
// Notes:   Purely combinational; the byte itself is held by the caller.
`timescale 1ns/10ps
module tpo_ndr_map
(
	input  wire logic       same_trig,
	input  wire logic [7:0] ndr_q,
	input  wire logic       wr_main,
	input  wire logic       wr_alt,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rd_main,
	output logic      [7:0] rd_alt,
	output logic      [7:0] ndr_d
);

	// Shared trigger: whole byte at the main slot, alternate slot all reserved ones.
	// Split triggers: upper nibble at main, lower nibble at alternate, rest reads ones.
	always_comb
	begin
		if (same_trig)
		begin
			rd_main = ndr_q;
			rd_alt  = tpo_pkg::BYTE_RSVD_ONES;
			ndr_d   = wr_main ? wdata : ndr_q;
		end
		else
		begin
			rd_main = {ndr_q[7:4], tpo_pkg::NIB_RSVD_ONES};
			rd_alt  = {tpo_pkg::NIB_RSVD_ONES, ndr_q[3:0]};
			ndr_d   = {(wr_main ? wdata[7:4] : ndr_q[7:4]),
				(wr_alt ? wdata[3:0] : ndr_q[3:0])};
		end
	end

endmodule : tpo_ndr_map

/* hdl/tpo_group.sv */
// Purpose: Trigger selection and non-overlap sequencing of one 4-pin group.
// Assumes: Compare-match inputs are one-cycle pulses on pclk.
// Notes:   A trigger during a running gap abandons the pending rising bits.
`timescale 1ns/10ps
module tpo_group
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] cmp_match,
	input  wire logic [7:0] gap_cycles,
	tpo_grp_if.grp          bus
);

	tpo_pkg::tpo_gstate_t state_q;
	logic [7:0]           cnt_q;
	logic [3:0]           pend_q;
	logic                 trig;
	logic [3:0]           falls;
	logic [3:0]           rises;

	// Trigger is the selected compare line; edges only count on enabled pins.
	assign trig  = cmp_match[bus.sel];
	assign falls = bus.ner & bus.port & ~bus.ndr;
	assign rises = bus.ner & ~bus.port & bus.ndr;

	// Update request: plain copy, or falls first and rises after the gap.
	always_comb
	begin
		bus.upd_en  = 4'h0;
		bus.upd_val = bus.ndr;
		if (trig && !bus.nov)
			bus.upd_en = bus.ner;
		else if (trig)
			bus.upd_en = falls;
		else if (state_q == tpo_pkg::TPO_GAP && cnt_q == 8'h01)
		begin
			bus.upd_en  = pend_q;
			bus.upd_val = 4'hF;
		end
	end

	// Gap sequencer; a zero gap still costs one cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= tpo_pkg::TPO_IDLE;
			cnt_q   <= 8'h00;
			pend_q  <= 4'h0;
		end
		else if (trig && bus.nov && rises != 4'h0)
		begin
			state_q <= tpo_pkg::TPO_GAP;
			cnt_q   <= (gap_cycles == 8'h00) ? 8'h01 : gap_cycles;
			pend_q  <= rises;
		end
		else if (trig || (state_q == tpo_pkg::TPO_GAP && cnt_q == 8'h01))
		begin
			state_q <= tpo_pkg::TPO_IDLE;
			pend_q  <= 4'h0;
		end
		else
		begin
			case (state_q)
				tpo_pkg::TPO_GAP: cnt_q <= cnt_q - 8'h01;
				default:          cnt_q <= 8'h00;
			endcase
		end
	end

endmodule : tpo_group

/* hdl/tpo_top.sv */
// Purpose: Timed pattern output block with its port data and pin function registers.
// Assumes: APB slave with zero wait states; compare inputs come from pclk logic.
// Notes:   Each register is one 32-bit word; narrow data sits in the low bits.
//
// Summary of operation
// - Four 4-pin groups, joint or independent.
// - Sixteen outputs, enable per bit.
// - Group trigger picked from four compare lines.
// - Non-overlap mode inserts programmable gap.
// - Selected compare events drive DMA requests.
// - Pattern-owned port data bits ignore writes.
// - Pin routes pattern only when function 11.
// - Decode index bits 27-24 and 8-0 only.
// - Low next byte at F5, split F5/F7.
// - High next byte at F4, split F4/F6.
// - Reset mode F0, trigger FF, gap 01, rest zero.
// - Byte and halfword access on every register.
// - Two pin function registers, two bits each.
// - Trigger copies enabled next bits to data.
// - Unused next-data slots read ones, unwritable.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module tpo_top
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  cmp_match,
	output logic      [3:0]  dma_req,
	output logic      [15:0] pattern_output_pins
);

	logic [15:0] port_b_output_data_q;
	logic [15:0] pin_function_high_pins_q;
	logic [15:0] pin_function_low_pins_q;
	logic [3:0]  pattern_output_mode_q;
	logic [7:0]  pattern_trigger_select_q;
	logic [7:0]  pattern_enable_high_q;
	logic [7:0]  pattern_enable_low_q;
	logic [7:0]  next_pattern_high_q;
	logic [7:0]  next_pattern_low_q;
	logic [7:0]  gap_cycles_q;
	logic [7:0]  next_pattern_high_d;
	logic [7:0]  next_pattern_low_d;
	logic [7:0]  rd_next_high;
	logic [7:0]  rd_next_high2;
	logic [7:0]  rd_next_low;
	logic [7:0]  rd_next_low2;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic [12:0] key;
	logic        acc_wr;
	logic [15:0] lane_mask;
	logic [15:0] enable_all;
	logic [31:0] pin_function_all;
	logic [15:0] upd_en;
	logic [15:0] upd_val;
	logic [15:0] sw_mask;
	logic [15:0] pins_d;
	logic        same_low;
	logic        same_high;
	logic        hit_port;
	logic        hit_pf_hi;
	logic        hit_pf_lo;
	logic        hit_mode;
	logic        hit_trig;
	logic        hit_en_hi;
	logic        hit_en_lo;
	logic        hit_nx_hi;
	logic        hit_nx_lo;
	logic        hit_nx_hi2;
	logic        hit_nx_lo2;
	logic        hit_gap;

	// The bus answers in the same cycle it sees the access phase.
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	assign key = tpo_pkg::tpo_key(paddr[31:2]);

	// Slot hits; aliases across the ignored index bits land on the same registers.
	assign hit_port   = key == tpo_pkg::tpo_key(tpo_pkg::IDX_PORT_DATA);
	assign hit_pf_hi  = key == tpo_pkg::tpo_key(tpo_pkg::IDX_PINFN_HIGH);
	assign hit_pf_lo  = key == tpo_pkg::tpo_key(tpo_pkg::IDX_PINFN_LOW);
	assign hit_mode   = key == tpo_pkg::tpo_key(tpo_pkg::IDX_MODE);
	assign hit_trig   = key == tpo_pkg::tpo_key(tpo_pkg::IDX_TRIG_SEL);
	assign hit_en_hi  = key == tpo_pkg::tpo_key(tpo_pkg::IDX_EN_HIGH);
	assign hit_en_lo  = key == tpo_pkg::tpo_key(tpo_pkg::IDX_EN_LOW);
	assign hit_nx_hi  = key == tpo_pkg::tpo_key(tpo_pkg::IDX_NEXT_HIGH);
	assign hit_nx_lo  = key == tpo_pkg::tpo_key(tpo_pkg::IDX_NEXT_LOW);
	assign hit_nx_hi2 = key == tpo_pkg::tpo_key(tpo_pkg::IDX_NEXT_HIGH2);
	assign hit_nx_lo2 = key == tpo_pkg::tpo_key(tpo_pkg::IDX_NEXT_LOW2);
	assign hit_gap    = key == tpo_pkg::tpo_key(tpo_pkg::IDX_GAP);

	assign acc_wr    = psel && penable && pwrite;
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// Flat views of the enable and pin function fields, pin p at bit p or 2p.
	// Per-bit enables
	assign enable_all       = {pattern_enable_high_q, pattern_enable_low_q};
	assign pin_function_all = {pin_function_high_pins_q, pin_function_low_pins_q};

	// Shared trigger tests select the next-data layout.
	assign same_low  = pattern_trigger_select_q[3:2] == pattern_trigger_select_q[1:0];
	assign same_high = pattern_trigger_select_q[7:6] == pattern_trigger_select_q[5:4];

	tpo_ndr_map u_map_low
	(
		.same_trig (same_low),
		.ndr_q     (next_pattern_low_q),
		.wr_main   (acc_wr && hit_nx_lo && pstrb[0]),
		.wr_alt    (acc_wr && hit_nx_lo2 && pstrb[0]),
		.wdata     (pwdata[7:0]),
		.rd_main   (rd_next_low),
		.rd_alt    (rd_next_low2),
		.ndr_d     (next_pattern_low_d)
	);

	tpo_ndr_map u_map_high
	(
		.same_trig (same_high),
		.ndr_q     (next_pattern_high_q),
		.wr_main   (acc_wr && hit_nx_hi && pstrb[0]),
		.wr_alt    (acc_wr && hit_nx_hi2 && pstrb[0]),
		.wdata     (pwdata[7:0]),
		.rd_main   (rd_next_high),
		.rd_alt    (rd_next_high2),
		.ndr_d     (next_pattern_high_d)
	);

	for (genvar g = 0; g < tpo_pkg::NUM_GROUPS; g++)
	begin : g_grp
		tpo_grp_if gif ();

		// Group g owns pins 4g+3..4g and trigger select bits 2g+1..2g.
		assign gif.sel  = pattern_trigger_select_q[2*g +: 2];
		assign gif.ner  = enable_all[4*g +: 4];
		assign gif.nov  = pattern_output_mode_q[tpo_pkg::MODE_NOV_LSB + g];
		assign gif.port = port_b_output_data_q[4*g +: 4];
		assign gif.ndr  = (g < 2) ? next_pattern_low_q[4*(g%2) +: 4]
			: next_pattern_high_q[4*(g%2) +: 4];

		tpo_group u_group
		(
			.pclk       (pclk),
			.presetn    (presetn),
			.cmp_match  (cmp_match),
			.gap_cycles (gap_cycles_q),
			.bus        (gif.grp)
		);

		assign upd_en[4*g +: 4]  = gif.upd_en & gif.ner;
		assign upd_val[4*g +: 4] = gif.upd_val;
	end

	// A compare line requests DMA when some group with an enabled pin uses it.
	for (genvar c = 0; c < tpo_pkg::NUM_CMP; c++)
	begin : g_dma
		logic [3:0] uses;
		for (genvar g = 0; g < tpo_pkg::NUM_GROUPS; g++)
		begin : g_use
			assign uses[g] = (pattern_trigger_select_q[2*g +: 2] == 2'(c))
				&& (enable_all[4*g +: 4] != 4'h0);
		end
		// The request is only as wide as the compare pulse, so the DMA side
		// must catch it on this same clock.
		// Trigger to DMA
		assign dma_req[c] = cmp_match[c] && (uses != 4'h0);
	end

	// Protection follows the enable bits alone, so a pin that serves another
	// function can still be locked against software writes.
	// Write protect on pattern bits
	assign sw_mask = (acc_wr && hit_port) ? (lane_mask & ~enable_all) : 16'h0000;

	// Port data: software writes free bits, triggers load pattern bits.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port_b_output_data_q <= tpo_pkg::RST_PORT_DATA;
		else
			port_b_output_data_q <= (port_b_output_data_q & ~sw_mask & ~upd_en)
				| (pwdata[15:0] & sw_mask) | (upd_val & upd_en);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_function_high_pins_q <= tpo_pkg::RST_PINFN;
			pin_function_low_pins_q  <= tpo_pkg::RST_PINFN;
		end
		else
		begin
			if (acc_wr && hit_pf_hi)
				pin_function_high_pins_q <= (pin_function_high_pins_q & ~lane_mask)
					| (pwdata[15:0] & lane_mask);
			if (acc_wr && hit_pf_lo)
				pin_function_low_pins_q <= (pin_function_low_pins_q & ~lane_mask)
					| (pwdata[15:0] & lane_mask);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pattern_output_mode_q    <= tpo_pkg::RST_MODE[3:0];
			pattern_trigger_select_q <= tpo_pkg::RST_TRIG_SEL;
			pattern_enable_high_q    <= tpo_pkg::RST_ENABLE;
			pattern_enable_low_q     <= tpo_pkg::RST_ENABLE;
			gap_cycles_q             <= tpo_pkg::RST_GAP;
		end
		else if (acc_wr && pstrb[0])
		begin
			if (hit_mode)
				pattern_output_mode_q <= pwdata[3:0];
			if (hit_trig)
				pattern_trigger_select_q <= pwdata[7:0];
			if (hit_en_hi)
				pattern_enable_high_q <= pwdata[7:0];
			if (hit_en_lo)
				pattern_enable_low_q <= pwdata[7:0];
			if (hit_gap)
				gap_cycles_q <= pwdata[7:0];
		end
	end

	// Next-data bytes take their lane-qualified values from the mappers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			next_pattern_high_q <= tpo_pkg::RST_NEXT;
			next_pattern_low_q  <= tpo_pkg::RST_NEXT;
		end
		else
		begin
			next_pattern_high_q <= next_pattern_high_d;
			next_pattern_low_q  <= next_pattern_low_d;
		end
	end

	// Read mux; unmapped slots read zero and raise an error.
	always_comb
	begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		if (hit_port)
			rd_word[15:0] = port_b_output_data_q;
		else if (hit_pf_hi)
			rd_word[15:0] = pin_function_high_pins_q;
		else if (hit_pf_lo)
			rd_word[15:0] = pin_function_low_pins_q;
		else if (hit_mode)
			rd_word[7:0] = {tpo_pkg::MODE_RSVD_ONES, pattern_output_mode_q};
		else if (hit_trig)
			rd_word[7:0] = pattern_trigger_select_q;
		else if (hit_en_hi)
			rd_word[7:0] = pattern_enable_high_q;
		else if (hit_en_lo)
			rd_word[7:0] = pattern_enable_low_q;
		else if (hit_nx_hi)
			rd_word[7:0] = rd_next_high;
		else if (hit_nx_lo)
			rd_word[7:0] = rd_next_low;
		else if (hit_nx_hi2)
			rd_word[7:0] = rd_next_high2;
		else if (hit_nx_lo2)
			rd_word[7:0] = rd_next_low2;
		else if (hit_gap)
			rd_word[7:0] = gap_cycles_q;
		else
			rd_hit = 1'b0;
	end

	// Read data and error are caught in the setup cycle so they leave a flop
	// at the access phase; the trade is one cycle of staleness on port data.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata_q  <= pwrite ? 32'h00000000 : rd_word;
			pslverr_q <= !rd_hit;
		end
		else if (psel && penable)
		begin
			// Ready never drops, so this edge ends the access and the bus idles at zero.
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
	end

	for (genvar p = 0; p < tpo_pkg::NUM_PINS; p++)
	begin : g_pin
		assign pins_d[p] = (pin_function_all[2*p +: 2] == tpo_pkg::PINFN_PATTERN)
			&& port_b_output_data_q[p];
	end

	// Pins leave a flop, one cycle behind port data.
	// A pin given another function shows low here; its own mux lies outside.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pattern_output_pins <= 16'h0000;
		else
			pattern_output_pins <= pins_d;
	end

endmodule : tpo_top

/* dv/tpo_top_properties.sv */
// Purpose: Concurrent checks on the port behaviour of the pattern output block.
// Assumes: Single pclk domain; presetn is the only reset.
// Notes:   Sees top-level ports only; attached by bind below.
`timescale 1ns/10ps
module tpo_top_properties
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [3:0]  cmp_match,
	input wire logic [3:0]  dma_req,
	input wire logic [15:0] pattern_output_pins
);
	// All checks share the bus clock and drop out while reset is low.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_ready_access; psel && penable |-> pready; endproperty
	a_ready_access: assert property (p_ready_access) else $error("no ready in access");
	property p_ready_next; psel && !penable ##1 penable |-> pready; endproperty
	a_ready_next: assert property (p_ready_next) else $error("access not zero wait");
	property p_idle_rdata; !psel |-> prdata == 32'h0; endproperty
	a_idle_rdata: assert property (p_idle_rdata) else $error("read data while idle");
	property p_err_only_access; pslverr |-> psel && penable; endproperty
	a_err_only_access: assert property (p_err_only_access) else $error("stray error");
	property p_err_reads_zero; psel && penable && pslverr |-> prdata == 32'h0; endproperty
	a_err_reads_zero: assert property (p_err_reads_zero) else $error("error with data");
	// Ignored index bits must not matter: any alias of the port data slot decodes.
	property p_alias_mapped;
		psel && penable && paddr[29:26] == 4'h5 && paddr[10:2] == 9'h1C2 |-> !pslverr;
	endproperty
	a_alias_mapped: assert property (p_alias_mapped) else $error("alias refused");
	property p_dma_from_match; (dma_req & ~cmp_match) == 4'h0; endproperty
	a_dma_from_match: assert property (p_dma_from_match) else $error("dma without match");
	property p_release_quiet; $rose(presetn) |-> pattern_output_pins == 16'h0000; endproperty
	a_release_quiet: assert property (p_release_quiet) else $error("pins after reset");
endmodule : tpo_top_properties

bind tpo_top tpo_top_properties u_tpo_top_properties
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cmp_match(cmp_match), .dma_req(dma_req),
	.pattern_output_pins(pattern_output_pins)
);

/* dv/tpo_timer_model.sv */
// Purpose: Stand-in for the companion timer and the DMA request sink.
// Assumes: Compare events are single-cycle pulses on pclk.
// Notes:   The bench fires channels on command; DMA requests are only counted.
`timescale 1ns/10ps
module tpo_timer_model
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] dma_req,
	output logic      [3:0] cmp_match
);
	int dma_cnt [4];

	initial cmp_match = 4'h0;

	task automatic fire(input int ch);
	begin
		cmp_match <= 4'h1 << ch;
		@(posedge pclk);
		cmp_match <= 4'h0;
	end
	endtask : fire

	always @(posedge pclk or negedge presetn)
	begin
		for (int c = 0; c < 4; c++)
		begin
			if (!presetn)
				dma_cnt[c] = 0;
			else if (dma_req[c] === 1'b1)
				dma_cnt[c]++;
		end
	end
endmodule : tpo_timer_model

/* dv/testbench.sv */
// Purpose: Directed register and pattern sequencing test of the output block.
// Assumes: Zero-wait APB slave; a slot index times four is the byte address.
// Notes:   Expected values are worked out by hand from the register layout.
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  cmp_match;
	logic [3:0]  dma_req;
	logic [15:0] pattern_output_pins;
	int          n_mismatch;
	int          samples_checked;

	tpo_top u_tpo_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp_match(cmp_match), .dma_req(dma_req),
		.pattern_output_pins(pattern_output_pins));
	tpo_timer_model u_tpo_timer_model (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
		.cmp_match(cmp_match));

	// Free-running 100 MHz clock.
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Single exit point of the run.
	task automatic finish_test();
	begin
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask : finish_test

	// One APB transfer; a spare edge at the end keeps back-to-back calls race free.
	task automatic apb(input logic wr_en, input logic [29:0] idx, input logic [31:0] wd,
		output logic [31:0] rd_v, output logic err);
		int n;
	begin
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		pstrb <= 4'h3;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd_v = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			finish_test();
		end
		@(posedge pclk);
	end
	endtask : apb

	task automatic wr(input logic [29:0] idx, input logic [31:0] d);
		logic [31:0] v;
		logic        e;
	begin
		apb(1'b1, idx, d, v, e);
	end
	endtask : wr

	task automatic rd(input string nm, input logic [29:0] idx, input logic [31:0] exp);
		logic [31:0] v;
		logic        e;
	begin
		apb(1'b0, idx, 32'h0, v, e);
		`CHK(nm, exp, v)
	end
	endtask : rd

	// Main sequence: reset values, decode, protection, triggers, non-overlap.
	initial
	begin
		logic [31:0] v;
		logic        e;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("port", tpo_pkg::IDX_PORT_DATA, 32'h0000);
		rd("fn hi", tpo_pkg::IDX_PINFN_HIGH, 32'h0000);
		rd("fn lo", tpo_pkg::IDX_PINFN_LOW, 32'h0000);
		rd("mode", tpo_pkg::IDX_MODE, 32'hF0);
		rd("trig", tpo_pkg::IDX_TRIG_SEL, 32'hFF);
		rd("en hi", tpo_pkg::IDX_EN_HIGH, 32'h00);
		rd("en lo", tpo_pkg::IDX_EN_LOW, 32'h00);
		rd("next hi", tpo_pkg::IDX_NEXT_HIGH, 32'h00);
		rd("next hi2", tpo_pkg::IDX_NEXT_HIGH2, 32'hFF);
		rd("next lo", tpo_pkg::IDX_NEXT_LOW, 32'h00);
		rd("next lo2", tpo_pkg::IDX_NEXT_LOW2, 32'hFF);
		rd("alias", 30'h05ABCFF1, 32'hFF);
		apb(1'b0, 30'h05FFFFF9, 32'h0, v, e);
		`CHK("unmapped", 1'b1, e)
		wr(tpo_pkg::IDX_PINFN_HIGH, 32'hC000);
		rd("fn hi", tpo_pkg::IDX_PINFN_HIGH, 32'hC000);
		wr(tpo_pkg::IDX_PINFN_LOW, 32'hFFFF);
		rd("fn lo", tpo_pkg::IDX_PINFN_LOW, 32'hFFFF);
		wr(tpo_pkg::IDX_PORT_DATA, 32'hFFFF);
		rd("port", tpo_pkg::IDX_PORT_DATA, 32'hFFFF);
		wr(tpo_pkg::IDX_TRIG_SEL, 32'hE4);
		wr(tpo_pkg::IDX_EN_HIGH, 32'h0F);
		wr(tpo_pkg::IDX_EN_LOW, 32'hFF);
		wr(tpo_pkg::IDX_PORT_DATA, 32'h8000);
		rd("port", tpo_pkg::IDX_PORT_DATA, 32'h8FFF);
		wr(tpo_pkg::IDX_NEXT_LOW, 32'hA5);
		rd("next lo", tpo_pkg::IDX_NEXT_LOW, 32'hAF);
		wr(tpo_pkg::IDX_NEXT_LOW2, 32'h5C);
		rd("next lo2", tpo_pkg::IDX_NEXT_LOW2, 32'hFC);
		wr(tpo_pkg::IDX_NEXT_HIGH, 32'h3C);
		rd("next hi", tpo_pkg::IDX_NEXT_HIGH, 32'h3F);
		wr(tpo_pkg::IDX_NEXT_HIGH2, 32'hE9);
		rd("next hi2", tpo_pkg::IDX_NEXT_HIGH2, 32'hF9);
		u_tpo_timer_model.fire(0);
		rd("port", tpo_pkg::IDX_PORT_DATA, 32'h8FFC);
		u_tpo_timer_model.fire(1);
		rd("port", tpo_pkg::IDX_PORT_DATA, 32'h8FAC);
		u_tpo_timer_model.fire(2);
		rd("port", tpo_pkg::IDX_PORT_DATA, 32'h89AC);
		u_tpo_timer_model.fire(3);
		rd("port", tpo_pkg::IDX_PORT_DATA, 32'h89AC);
		`CHK("pins", 16'h80AC, pattern_output_pins)
		for (int c = 0; c < 4; c++)
			`CHK("dma", (c < 3) ? 1 : 0, u_tpo_timer_model.dma_cnt[c])
		// Shared trigger: whole bytes at the main slots, alternates reserved.
		wr(tpo_pkg::IDX_TRIG_SEL, 32'h00);
		rd("next lo", tpo_pkg::IDX_NEXT_LOW, 32'hAC);
		rd("next hi", tpo_pkg::IDX_NEXT_HIGH, 32'h39);
		wr(tpo_pkg::IDX_NEXT_LOW, 32'h53);
		wr(tpo_pkg::IDX_NEXT_LOW2, 32'h00);
		rd("next lo", tpo_pkg::IDX_NEXT_LOW, 32'h53);
		rd("next lo2", tpo_pkg::IDX_NEXT_LOW2, 32'hFF);
		// Non-overlap on group 0: falling bits first, rising bits after the gap.
		wr(tpo_pkg::IDX_MODE, 32'h01);
		rd("mode", tpo_pkg::IDX_MODE, 32'hF1);
		wr(tpo_pkg::IDX_GAP, 32'h03);
		wr(tpo_pkg::IDX_EN_HIGH, 32'h00);
		wr(tpo_pkg::IDX_EN_LOW, 32'h0F);
		u_tpo_timer_model.fire(0);
		repeat (3) @(posedge pclk);
		#1;
		`CHK("pins gap", 16'h80A0, pattern_output_pins)
		repeat (1) @(posedge pclk);
		#1;
		`CHK("pins end", 16'h80A3, pattern_output_pins)
		finish_test();
	end
endmodule : testbench
